//--- rtl/pmr_top.sv
// Purpose: management register bank with the basic mode control register
// Assumes: mdc and mdio are synchronous to clk and much slower than it
// Notes: the analog calibration and negotiation engines sit outside
`default_nettype none
module pmr_top
  import pmr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // management lines
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out_q,
  output logic mdio_oe_q,
  // dedicated control pins and straps
  input wire logic loopback_pin,
  input wire logic power_down_pin,
  input wire logic reset_pin,
  input wire logic [4:0] strapped_mgmt_address,
  input wire logic isolate_default_strap,
  input wire logic [1:0] negotiation_mode_straps,
  // analog and negotiation engines
  input wire logic analog_cal_busy,
  input wire logic analog_cal_done,
  input wire logic an_started,
  input wire logic an_complete,
  input wire logic an_speed_100,
  input wire logic an_full_duplex,
  input wire logic [15:0] an_partner_word,
  input wire logic link_up,
  // line events
  input wire logic link_disconnect_evt,
  input wire logic false_carrier_evt,
  input wire logic rx_error_evt,
  // mii transmit side and collision
  input wire logic tx_en,
  input wire logic col_in,
  // mode outputs
  output logic col_out_q,
  output logic mii_oe_q,
  output logic loopback_en_q,
  output logic speed_100_q,
  output logic full_duplex_q,
  output logic power_down_q,
  output logic an_enable_q,
  output logic an_restart_q,
  output logic calib_req_q
);
  pmr_mem_if mi();
  pmr_state_t st_q;
  logic [4:0] cnt_q, addr_q;
  logic [15:0] sh_q, rd_sh_q, tencfg_q;
  logic mdc_prev_q, rd_q, lp_prev_q, strap_ld_q, soft_clr_q;
  logic rst_pend_q, loopback_pin_q, speed_q, an_en_q, pdn_q, iso_q, an_rst_q, dup_q, colt_q;
  logic [15:0] disc_cnt, fcar_cnt, rxe_cnt;
  logic mdc_rise, mdc_fall, init, wr_go, wr_ctrl, compat;
  logic [15:0] wr_data, rd_word;
  logic [3:0] word_idx;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // store index for the plain read/write words
  function automatic logic [3:0] mem_idx(input logic [4:0] a);
    unique case (a)
      ADDR_ADV: mem_idx = 4'h8;
      ADDR_NXTPG: mem_idx = 4'h9;
      ADDR_IMASK: mem_idx = 4'ha;
      ADDR_SCRSEED: mem_idx = 4'hb;
      ADDR_DSCSEED: mem_idx = 4'hc;
      ADDR_PCSCFG: mem_idx = 4'hd;
      ADDR_LBERR: mem_idx = 4'he;
      ADDR_SELF: mem_idx = 4'hf;
      default: mem_idx = 4'h0;
    endcase
  endfunction

  // control word as read back
  function automatic logic [15:0] ctrl_word(input logic busy);
    ctrl_word = 16'h0000;
    ctrl_word[B_SRST] = busy;
    ctrl_word[B_LOOPBACK_PIN] = loopback_pin_q;
    ctrl_word[B_SPEED] = speed_q;
    ctrl_word[B_ANEN] = an_en_q;
    ctrl_word[B_PDN] = pdn_q;
    ctrl_word[B_ISO] = iso_q;
    ctrl_word[B_ANRST] = an_rst_q;
    ctrl_word[B_DUP] = dup_q;
    ctrl_word[B_COLT] = colt_q;
  endfunction

  assign mdc_rise = mdc && !mdc_prev_q;
  assign mdc_fall = !mdc && mdc_prev_q;
  assign init = strap_ld_q || reset_pin || soft_clr_q;
  assign wr_data = {sh_q[14:0], mdio_in};
  assign wr_go = mdc_rise && st_q == ST_DATA && cnt_q == 5'd15 && !rd_q;
  assign wr_ctrl = wr_go && addr_q == ADDR_CTRL;
  assign compat = tencfg_q[B_COMPAT];
  // store index held in a net, a call result cannot be bit-selected
  assign word_idx = mem_idx(addr_q);

  // ----------------------------------------
  // management frame receiver
  // ----------------------------------------
  // start, opcode, addresses
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_q <= ST_IDLE;
      cnt_q <= 5'd0;
      addr_q <= 5'd0;
      sh_q <= 16'h0000;
      rd_q <= 1'b0;
      mdc_prev_q <= 1'b0;
    end
    else if (clk_en)
    begin
      mdc_prev_q <= mdc;
      if (mdc_rise)
      begin
        sh_q <= wr_data;
        cnt_q <= cnt_q + 5'd1;
        unique case (st_q)
          ST_IDLE: if (!mdio_in) st_q <= ST_START;
          ST_START: st_q <= mdio_in ? ST_OP : ST_IDLE;
          ST_OP:
          begin
            if (cnt_q == 5'd1)
            begin
              rd_q <= sh_q[0];
              cnt_q <= 5'd0;
              st_q <= (sh_q[0] != mdio_in) ? ST_PHY : ST_SKIP;
            end
            else
              cnt_q <= 5'd1;
          end
          ST_PHY:
          begin
            if (cnt_q == 5'd4)
            begin
              cnt_q <= 5'd0;
              st_q <= (wr_data[4:0] == 5'd0 || wr_data[4:0] == strapped_mgmt_address) ?
                      ST_REG : ST_SKIP;
            end
          end
          ST_REG:
          begin
            if (cnt_q == 5'd4)
            begin
              cnt_q <= 5'd0;
              addr_q <= wr_data[4:0];
              st_q <= ST_TA;
            end
          end
          ST_TA:
          begin
            if (cnt_q == 5'd1)
            begin
              cnt_q <= 5'd0;
              st_q <= ST_DATA;
            end
          end
          ST_DATA: if (cnt_q == 5'd15) st_q <= ST_IDLE;
          ST_SKIP: if (cnt_q == 5'd22) st_q <= ST_IDLE;
        endcase
        if (st_q == ST_IDLE || st_q == ST_START)
          cnt_q <= 5'd0;
      end
    end
  end

  // read word for the latched address
  // implemented map, rest zero
  always_comb
  begin
    rd_word = 16'h0000;
    unique case (addr_q)
      ADDR_CTRL: rd_word = ctrl_word(rst_pend_q || analog_cal_busy);
      ADDR_STAT: rd_word = {1'b0, mi.rdata[8:5], 4'h0, 1'b1, an_complete, 2'b00,
                            link_up, 2'b01};
      ADDR_IDH: rd_word = ID_HIGH;
      ADDR_IDL: rd_word = ID_LOW;
      ADDR_PARTNER: rd_word = an_partner_word;
      ADDR_DISC: rd_word = disc_cnt;
      ADDR_FCAR: rd_word = fcar_cnt;
      ADDR_RXERR: rd_word = rxe_cnt;
      ADDR_TENCFG: rd_word = tencfg_q;
      default: rd_word = word_idx[3] ? mi.rdata : 16'h0000;
    endcase
  end

  // status needs the advertisement word, any other address selects its plain word
  assign mi.ridx = (addr_q == ADDR_STAT) ? 3'd0 : word_idx[2:0];
  assign mi.we = wr_go && word_idx[3];
  assign mi.widx = word_idx[2:0];
  assign mi.wdata = wr_data;
  assign mi.clr = init;

  // ----------------------------------------
  // management data driver
  // ----------------------------------------
  // turnaround then msb first
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rd_sh_q <= 16'h0000;
      mdio_out_q <= 1'b1;
      mdio_oe_q <= 1'b0;
    end
    else if (clk_en)
    begin
      // store read data is registered, so load on the first rise of the turnaround, one bit after the address latches
      if (mdc_rise && st_q == ST_TA && cnt_q == 5'd0)
        rd_sh_q <= rd_word;
      if (mdc_fall)
      begin
        if (st_q == ST_TA && cnt_q == 5'd1 && rd_q)
        begin
          mdio_oe_q <= 1'b1;
          mdio_out_q <= 1'b0;
        end
        else if (st_q == ST_DATA && rd_q)
        begin
          mdio_oe_q <= 1'b1;
          mdio_out_q <= rd_sh_q[15];
          rd_sh_q <= {rd_sh_q[14:0], 1'b0};
        end
        else
        begin
          mdio_oe_q <= 1'b0;
          mdio_out_q <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // reset sequencing
  // ----------------------------------------
  // straps are caught in the first cycle after release
  // soft reset and self-clear
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      strap_ld_q <= 1'b1;
      soft_clr_q <= 1'b0;
      rst_pend_q <= 1'b0;
      calib_req_q <= 1'b0;
    end
    else if (clk_en)
    begin
      strap_ld_q <= 1'b0;
      soft_clr_q <= wr_ctrl && wr_data[B_SRST];
      calib_req_q <= wr_ctrl && wr_data[B_SRST];
      if (reset_pin)
        rst_pend_q <= 1'b0;
      else if (wr_ctrl && wr_data[B_SRST])
        rst_pend_q <= 1'b1;
      else if (analog_cal_done && !soft_clr_q)
        rst_pend_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // basic mode control fields
  // ----------------------------------------
  // bits 6..0 have no storage
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      speed_q <= 1'b0;
      an_en_q <= 1'b0;
      dup_q <= 1'b0;
      iso_q <= 1'b1;
      pdn_q <= 1'b0;
      colt_q <= 1'b0;
      tencfg_q <= TENCFG_RST;
    end
    else if (clk_en)
    begin
      if (init)
      begin
        iso_q <= (strapped_mgmt_address == 5'd0) || isolate_default_strap;
        an_en_q <= negotiation_mode_straps == AN_STRAP_ON;
        speed_q <= negotiation_mode_straps[1];
        dup_q <= negotiation_mode_straps[0];
        pdn_q <= 1'b0;
        colt_q <= 1'b0;
        tencfg_q <= TENCFG_RST;
      end
      else if (wr_go && addr_q == ADDR_TENCFG)
        tencfg_q <= wr_data;
      else if (wr_ctrl)
      begin
        speed_q <= wr_data[B_SPEED];
        an_en_q <= wr_data[B_ANEN];
        iso_q <= wr_data[B_ISO];
        dup_q <= wr_data[B_DUP];
        colt_q <= wr_data[B_COLT];
        if (!compat)
          pdn_q <= wr_data[B_PDN];
      end
    end
  end

  // loopback bit, pin edges win over software
  // follows pin edges
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      loopback_pin_q <= 1'b0;
      lp_prev_q <= 1'b0;
    end
    else if (clk_en)
    begin
      lp_prev_q <= loopback_pin;
      if (loopback_pin && !lp_prev_q)
        loopback_pin_q <= 1'b1;
      else if (!loopback_pin && lp_prev_q)
        loopback_pin_q <= 1'b0;
      else if (init)
        loopback_pin_q <= 1'b0;
      else if (wr_ctrl)
        loopback_pin_q <= wr_data[B_LOOPBACK_PIN];
    end
  end

  // restart request: a write of one wins over the engine's start
  // self-clears on start
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      an_rst_q <= 1'b0;
    else if (clk_en)
    begin
      if (init)
        an_rst_q <= 1'b0;
      else if (wr_ctrl && wr_data[B_ANRST])
        an_rst_q <= 1'b1;
      else if (an_started)
        an_rst_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // mode outputs
  // ----------------------------------------
  // pins act directly on outputs
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      col_out_q <= 1'b0;
      mii_oe_q <= 1'b0;
      loopback_en_q <= 1'b0;
      speed_100_q <= 1'b0;
      full_duplex_q <= 1'b0;
      power_down_q <= 1'b0;
      an_enable_q <= 1'b0;
      an_restart_q <= 1'b0;
    end
    else if (clk_en)
    begin
      col_out_q <= colt_q ? (tx_en && !iso_q) : col_in;
      mii_oe_q <= !iso_q;
      loopback_en_q <= loopback_pin_q || loopback_pin;
      speed_100_q <= an_en_q ? an_speed_100 : speed_q;
      full_duplex_q <= an_en_q ? an_full_duplex : dup_q;
      power_down_q <= power_down_pin || (pdn_q && !compat);
      an_enable_q <= an_en_q;
      an_restart_q <= an_rst_q;
    end
  end

  // ----------------------------------------
  // storage and counters
  // ----------------------------------------
  pmr_mem u_mem (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .m(mi.store));
  pmr_counter u_disc (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .clr(init),
    .inc(link_disconnect_evt), .cnt_q(disc_cnt));
  pmr_counter u_fcar (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .clr(init),
    .inc(false_carrier_evt), .cnt_q(fcar_cnt));
  pmr_counter u_rxe (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .clr(init),
    .inc(rx_error_evt), .cnt_q(rxe_cnt));

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  rsvd_read_zero_a: assert property (
    (clk_en && mdc_rise && st_q == ST_TA && cnt_q == 5'd0 && addr_q[4:3] == 2'b01)
    |=> rd_sh_q == 16'h0000) else $error("reserved address read not zero");
  loopback_pin_pin_rise_a: assert property (
    (clk_en && loopback_pin && !lp_prev_q) |=> loopback_pin_q ##1 (!clk_en || loopback_en_q))
    else $error("loopback bit missed pin rise");
  loopback_pin_pin_fall_a: assert property (
    (clk_en && !loopback_pin && lp_prev_q) |=> !loopback_pin_q) else $error("loopback not cleared");
  pdn_compat_hold_a: assert property (
    (clk_en && compat && !init) |=> pdn_q == $past(pdn_q))
    else $error("power down changed in compatibility mode");
  colt_assert_a: assert property (
    (clk_en && colt_q && tx_en && !iso_q) |=> col_out_q) else $error("collision test late");
  soft_rst_seq_a: assert property (
    (clk_en && wr_ctrl && wr_data[B_SRST] && !reset_pin)
    |=> rst_pend_q && soft_clr_q && calib_req_q) else $error("soft reset not started");
  phy_ignore_a: assert property (
    (clk_en && mdc_rise && st_q == ST_PHY && cnt_q == 5'd4 && wr_data[4:0] != 5'd0
     && wr_data[4:0] != strapped_mgmt_address) |=> st_q == ST_SKIP)
    else $error("foreign frame not skipped");
  an_restart_clr_a: assert property (
    (clk_en && an_started && !(wr_ctrl && wr_data[B_ANRST])) |=> !an_rst_q)
    else $error("restart bit stuck");
  ta_drive_zero_a: assert property (
    (clk_en && mdc_fall && st_q == ST_TA && cnt_q == 5'd1 && rd_q)
    |=> mdio_oe_q && !mdio_out_q) else $error("turnaround zero missing");
  speed_forced_a: assert property (
    (clk_en && !an_en_q) |=> (!clk_en || speed_100_q == $past(speed_q)))
    else $error("forced speed not applied");

  read_frame_c: cover property (clk_en && mdc_rise && st_q == ST_DATA && rd_q);
  write_ctrl_c: cover property (clk_en && wr_ctrl);
  colt_c: cover property (clk_en && colt_q && col_out_q);
endmodule
`default_nettype wire

//--- rtl/pmr_pkg.sv
// Purpose: shared constants for the phy management register bank
// Assumes: 16-bit registers, 5-bit register and phy addresses
// Notes: offsets are management register addresses, not byte addresses
`default_nettype none
package pmr_pkg;
  // ----------------------------------------
  // register addresses
  // ----------------------------------------
  localparam logic [4:0] ADDR_CTRL = 5'h00;
  localparam logic [4:0] ADDR_STAT = 5'h01;
  localparam logic [4:0] ADDR_IDH = 5'h02;
  localparam logic [4:0] ADDR_IDL = 5'h03;
  localparam logic [4:0] ADDR_ADV = 5'h04;
  localparam logic [4:0] ADDR_PARTNER = 5'h05;
  localparam logic [4:0] ADDR_EXPAN = 5'h06;
  localparam logic [4:0] ADDR_NXTPG = 5'h07;
  localparam logic [4:0] ADDR_IMASK = 5'h10;
  localparam logic [4:0] ADDR_ISTAT = 5'h11;
  localparam logic [4:0] ADDR_DISC = 5'h12;
  localparam logic [4:0] ADDR_FCAR = 5'h13;
  localparam logic [4:0] ADDR_SCRSEED = 5'h14;
  localparam logic [4:0] ADDR_RXERR = 5'h15;
  localparam logic [4:0] ADDR_DSCSEED = 5'h16;
  localparam logic [4:0] ADDR_PCSCFG = 5'h17;
  localparam logic [4:0] ADDR_LBERR = 5'h18;
  localparam logic [4:0] ADDR_SELF = 5'h19;
  localparam logic [4:0] ADDR_TENSTAT = 5'h1b;
  localparam logic [4:0] ADDR_TENCFG = 5'h1c;
  // ----------------------------------------
  // control register field positions
  // ----------------------------------------
  localparam int B_SRST = 15;
  localparam int B_LOOPBACK_PIN = 14;
  localparam int B_SPEED = 13;
  localparam int B_ANEN = 12;
  localparam int B_PDN = 11;
  localparam int B_ISO = 10;
  localparam int B_ANRST = 9;
  localparam int B_DUP = 8;
  localparam int B_COLT = 7;
  localparam int B_COMPAT = 5; // compatibility mode bit in ten_meg_config
  // ----------------------------------------
  // reset values and identity
  // ----------------------------------------
  localparam logic [15:0] ADV_RST = 16'h01e1;
  localparam logic [15:0] TENCFG_RST = 16'h0000;
  localparam logic [15:0] ID_HIGH = 16'h1234; // arbitrary value
  localparam logic [15:0] ID_LOW = 16'h5670; // arbitrary value
  localparam logic [1:0] AN_STRAP_ON = 2'b11;
  // ----------------------------------------
  // timing: collision test response
  // ----------------------------------------
  localparam int CLK_NS = 100;
  localparam int BIT_NS_FAST = 10;
  localparam int COLT_ON_BT = 10;
  localparam int COLT_ON_CYC = (COLT_ON_BT * BIT_NS_FAST / CLK_NS < 1) ? 1 :
                               COLT_ON_BT * BIT_NS_FAST / CLK_NS;
  // ----------------------------------------
  // management frame states
  // ----------------------------------------
  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_OP, ST_PHY, ST_REG, ST_TA, ST_DATA,
                            ST_SKIP} pmr_state_t;
endpackage
`default_nettype wire

//--- rtl/pmr_mem_if.sv
// Purpose: carrier between the bank and its word store
// Assumes: one write and one read port, registered read
// Notes: clr restores reset values in one cycle
`default_nettype none
interface pmr_mem_if;
  logic we;
  logic [2:0] widx;
  logic [15:0] wdata;
  logic [2:0] ridx;
  logic [15:0] rdata;
  logic clr;
  modport bank (output we, widx, wdata, ridx, clr, input rdata);
  modport store (input we, widx, wdata, ridx, clr, output rdata);
endinterface
`default_nettype wire

//--- rtl/pmr_mem.sv
// Purpose: eight read/write words of the bank
// Assumes: clr is a synchronous chip-wide reset
// Notes: read data come out of a register
`default_nettype none
module pmr_mem
  import pmr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // store side
  pmr_mem_if.store m
);
  logic [15:0] word_q [8];

  // ----------------------------------------
  // word storage
  // ----------------------------------------
  // only the advertisement word has a non-zero default
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < 8; i++)
        word_q[i] <= (i == 0) ? ADV_RST : 16'h0000;
    end
    else if (clk_en)
    begin
      if (m.clr)
      begin
        for (int i = 0; i < 8; i++)
          word_q[i] <= (i == 0) ? ADV_RST : 16'h0000;
      end
      else if (m.we)
        word_q[m.widx] <= m.wdata;
    end
  end

  // registered read port
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      m.rdata <= 16'h0000;
    else if (clk_en)
      m.rdata <= word_q[m.ridx];
  end
endmodule
`default_nettype wire

//--- rtl/pmr_counter.sv
// Purpose: saturating read-only event counter
// Assumes: inc is a one-cycle pulse in the clk domain
// Notes: saturates rather than wrapping so a large count is never lost
`default_nettype none
module pmr_counter
  import pmr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic clr,
  // event and count
  input wire logic inc,
  output logic [15:0] cnt_q
);
  // count up to all ones
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      cnt_q <= 16'h0000;
    else if (clk_en)
    begin
      if (clr)
        cnt_q <= 16'h0000;
      else if (inc && cnt_q != 16'hffff)
        cnt_q <= cnt_q + 16'h0001;
    end
  end
endmodule
`default_nettype wire

//--- testbench/pmr_mac_model.sv
// Purpose: station manager issuing management frames
// Assumes: mdc half period of three clk cycles
// Notes: mdc stands still between frames
`default_nettype none
module pmr_mac_model (
  // clock
  input wire logic clk,
  // management lines
  output logic mdc,
  output logic mdio_oe,
  output logic mdio_drv,
  input wire logic mdio_line,
  // returned read word
  output logic rd_stb,
  output logic [15:0] rd_word
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle lines from time zero
  initial
  begin
    mdc = 1'h0;
    mdio_oe = 1'h0;
    mdio_drv = 1'h1;
    rd_stb = 1'h0;
    rd_word = 16'h0000;
  end
  // ----------------------------------------
  // frames
  // ----------------------------------------
  // one bit; data moves only after a fall, so it is settled at the rise
  task automatic bit_cyc(input logic oe, input logic b, output logic s);
    mdio_oe = oe;
    mdio_drv = b;
    repeat (3) @(posedge clk);
    #1 mdc = 1'h1;
    s = mdio_line;
    repeat (3) @(posedge clk);
    #1 mdc = 1'h0;
  endtask
  task automatic frame(input logic rd, input logic [4:0] phy, input logic [4:0] ra,
    input logic [15:0] wd);
    logic [31:0] f;
    logic s;
    // read frees turnaround, write drives one then zero
    f = {2'h1, rd ? 2'h2 : 2'h1, phy, ra, rd ? 2'h3 : 2'h2, wd};
    for (int i = 31; i >= 0; i--)
    begin
      bit_cyc(!(rd && i < 18), f[i], s);
      if (i < 16)
        rd_word[i] = s;
    end
    // spare period lets the device release the line
    bit_cyc(1'h0, 1'h1, s);
    rd_stb = rd;
    @(posedge clk);
    #1 rd_stb = 1'h0;
  endtask
endmodule
`default_nettype wire

//--- testbench/phy_mgmt_register_map_bmcr_tb_top.sv
// Purpose: self-checking bench of the management register bank
// Assumes: straps give 100 Mb/s half duplex, no negotiation
// Notes: a watcher checks read words against queued notes
`default_nettype none
module phy_mgmt_register_map_bmcr_tb_top
  import pmr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'h0, sys_rst = 1'h1, loopback_pin = 1'h0, power_down_pin = 1'h0;
  logic reset_pin = 1'h0, analog_cal_busy = 1'h0, analog_cal_done = 1'h0;
  logic an_started = 1'h0, tx_en = 1'h0, col_in = 1'h0;
  logic an_speed_100 = 1'h1, an_full_duplex = 1'h1;
  logic an_complete = 1'h0, link_up = 1'h0, isolate_default_strap = 1'h0;
  logic [1:0] negotiation_mode_straps = 2'h2;
  logic [2:0] ev = 3'h0;
  logic [4:0] strapped_mgmt_address = 5'h05;
  logic [15:0] an_partner_word = 16'h0000;
  logic [16:0] rnd = 17'h16e7f;
  logic [15:0] exp_q[$];
  logic [4:0] map_a[13] = '{ADDR_ADV, ADDR_NXTPG, ADDR_IMASK, ADDR_SCRSEED, ADDR_DSCSEED,
    ADDR_PCSCFG, ADDR_LBERR, ADDR_SELF, ADDR_DISC, 5'h08, 5'h0f, 5'h1a, 5'h1f};
  logic [4:0] cnt_a[3] = '{ADDR_DISC, ADDR_FCAR, ADDR_RXERR};
  int mismatches = 0, check_count = 0, calib_n = 0;
  wire [15:0] o;
  wire [15:0] rd_word;
  wire mdc, mac_oe, mac_drv, mdio_out_q, mdio_oe_q, rd_stb;
  // resolved line, pulled up when free
  wire mdio_in = mdio_oe_q ? mdio_out_q : (mac_oe ? mac_drv : 1'h1);
  assign o[15:9] = 7'h00;
  always #50 clk = ~clk;
  pmr_top dut (.clk, .sys_rst, .clk_en(1'h1), .mdc, .mdio_in, .mdio_out_q, .mdio_oe_q,
    .loopback_pin, .power_down_pin, .reset_pin, .strapped_mgmt_address,
    .isolate_default_strap, .negotiation_mode_straps, .analog_cal_busy,
    .analog_cal_done, .an_started, .an_complete, .an_speed_100, .an_full_duplex,
    .an_partner_word, .link_up, .link_disconnect_evt(ev[0]),
    .false_carrier_evt(ev[1]), .rx_error_evt(ev[2]), .tx_en, .col_in,
    .col_out_q(o[8]), .mii_oe_q(o[7]), .loopback_en_q(o[6]), .speed_100_q(o[5]),
    .full_duplex_q(o[4]), .power_down_q(o[3]), .an_enable_q(o[2]),
    .an_restart_q(o[1]), .calib_req_q(o[0]));
  pmr_mac_model mac (.clk, .mdc, .mdio_oe(mac_oe), .mdio_drv(mac_drv),
    .mdio_line(mdio_in), .rd_stb, .rd_word);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [16:0] lfsr(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    mac.frame(1'h0, strapped_mgmt_address, a, d);
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    mac.frame(1'h1, strapped_mgmt_address, a, 16'h0000);
  endtask
  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // watcher: each read word against the oldest note
  always @(posedge clk)
    if (rd_stb)
      chk(rd_word, exp_q.pop_front());
  // recalibration requests, too short to see from the sequence
  always @(posedge clk)
    if (o[0] === 1'h1)
      calib_n++;
  // watchdog against a hung handshake
  initial
  begin
    repeat (60000) @(posedge clk);
    mismatches++;
    report_and_stop();
  end
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial
  begin
    repeat (16) @(posedge clk);
    #1 sys_rst = 1'h0;
    cyc(3);
    rnd = lfsr(rnd);
    an_partner_word = rnd[15:0];
    rd(ADDR_CTRL, 16'h2000);
    rd(ADDR_IDH, ID_HIGH);
    rd(ADDR_IDL, ID_LOW);
    rd(ADDR_PARTNER, rnd[15:0]);
    col_in = 1'h1;
    cyc(2);
    chk(o, 16'h01a0);
    col_in = 1'h0;
    $display("test reset done");
    foreach (map_a[i])
    begin
      rnd = lfsr(rnd);
      wr(map_a[i], rnd[15:0]);
      rd(map_a[i], i < 8 ? rnd[15:0] : 16'h0000);
    end
    for (int i = 0; i < 3; i++)
    begin
      repeat (i + 2)
      begin
        ev[i] = 1'h1;
        cyc(1);
        ev[i] = 1'h0;
        cyc(1);
      end
      rd(cnt_a[i], 16'(i + 2));
    end
    $display("test map done");
    wr(ADDR_CTRL, 16'h23ff);
    rd(ADDR_CTRL, 16'h2380);
    chk(o, 16'h00b2);
    an_started = 1'h1;
    cyc(1);
    an_started = 1'h0;
    rd(ADDR_CTRL, 16'h2180);
    tx_en = 1'h1;
    cyc(2);
    chk(o, 16'h01b0);
    tx_en = 1'h0;
    an_speed_100 = 1'h0;
    an_full_duplex = 1'h0;
    wr(ADDR_CTRL, 16'h3100);
    chk(o, 16'h0084);
    an_speed_100 = 1'h1;
    cyc(2);
    chk(o, 16'h00a4);
    wr(ADDR_CTRL, 16'h0c00);
    chk(o, 16'h0008);
    wr(ADDR_CTRL, 16'h0000);
    wr(ADDR_TENCFG, 16'h0020);
    wr(ADDR_CTRL, 16'h0800);
    rd(ADDR_CTRL, 16'h0000);
    power_down_pin = 1'h1;
    cyc(2);
    chk(o, 16'h0088);
    power_down_pin = 1'h0;
    loopback_pin = 1'h1;
    rd(ADDR_CTRL, 16'h4000);
    chk(o, 16'h00c0);
    loopback_pin = 1'h0;
    rd(ADDR_CTRL, 16'h0000);
    mac.frame(1'h0, 5'h09, ADDR_CTRL, 16'h1000);
    rd(ADDR_CTRL, 16'h0000);
    $display("test control done");
    wr(ADDR_CTRL, 16'h8000);
    rd(ADDR_CTRL, 16'ha000);
    rd(ADDR_ADV, ADV_RST);
    an_complete = 1'h1;
    link_up = 1'h1;
    rd(ADDR_STAT, 16'h7865);
    rd(ADDR_TENCFG, TENCFG_RST);
    chk(16'(calib_n), 16'h0001);
    analog_cal_done = 1'h1;
    cyc(1);
    analog_cal_done = 1'h0;
    rd(ADDR_CTRL, 16'h2000);
    analog_cal_busy = 1'h1;
    rd(ADDR_CTRL, 16'ha000);
    analog_cal_busy = 1'h0;
    strapped_mgmt_address = 5'h00;
    reset_pin = 1'h1;
    cyc(2);
    reset_pin = 1'h0;
    cyc(2);
    rd(ADDR_CTRL, 16'h2400);
    rd(ADDR_RXERR, 16'h0000);
    chk(o, 16'h0020);
    // strap-driven defaults: isolate from its strap, negotiation on
    isolate_default_strap = 1'h1;
    negotiation_mode_straps = 2'h3;
    strapped_mgmt_address = 5'h05;
    reset_pin = 1'h1;
    cyc(2);
    reset_pin = 1'h0;
    cyc(2);
    rd(ADDR_CTRL, 16'h3500);
    chk(o, 16'h0024);
    $display("test resets done");
    report_and_stop();
  end
endmodule
`default_nettype wire
